/* File: rtl/chbi_defines.vh */
// Constants for the processor host bus interface block.
`ifndef CHBI_DEFINES_VH
`define CHBI_DEFINES_VH
`define CHBI_BURST_BEATS 4
`define CHBI_WAIT_CYCLES 1
`define CHBI_PORT_KBC 16'h0064
`define CHBI_PORT_SYSCTL 16'h0092
`define CHBI_KBC_RESET_CMD 8'hfe
`define CHBI_SYSCTL_INIT_BIT 0
`define CHBI_SYSCTL_A20_BIT 1
`define CHBI_INIT_PULSE_CYCLES 16
`define CHBI_RESET_CYCLES 32
`endif

/* File: rtl/chbi_host_bus.v */
// Processor host bus interface: cycle completion, snoops, hold and sideband pins.
`timescale 1ns/1ps
`include "chbi_defines.vh"
// Operation
// [RULE_01] Names ending _n are asserted low; all others are asserted high.
// [RULE_02] Processor pulses addr_strobe_n low in the first clock of each cycle.
// [RULE_03] Byte enables arrive with addr_strobe_n and address, selecting bytes.
// [RULE_04] data_code_sel stays valid until after next_addr_n or last burst_ready_n.
// [RULE_05] mem_io_sel stays valid likewise; it separates memory and I/O cycles.
// [RULE_06] Device pulses burst_ready_n low to finish each transfer of the cycle.
// [RULE_07] Device asserts next_addr_n to allow a pipelined next cycle.
// [RULE_08] Device asserts cache_enable_n to mark a cycle cacheable.
// [RULE_09] Processor flags burstable operations on burstable_req_n; device samples it.
// [RULE_10] Address pins are inputs in processor cycles, driven in master cycles.
// [RULE_11] Device asserts ext_addr_strobe_n after driving a valid snoop address.
// [RULE_12] On hit_modified_n the master cycle waits for writeback, then restarts.
// [RULE_13] addr_hold with ext_addr_strobe_n write-protects a cacheable ROM region.
// [RULE_14] Device drives snoop_invalidate during snoops to invalidate the line.
// [RULE_15] Device raises bus_request_out and waits for bus_grant_ack before mastering; in alternate pin mode the code skips both and asserts backoff_n instead.
// [RULE_16] In alternate pin mode, backoff_n forces the processor off next clock.
// [RULE_17] In alternate mode, atomic_seq_n sequences are never broken.
// [RULE_18] cpu_init pulses on reset writes to port 64 or 92, or shutdown.
// [RULE_19] addr20_mask_n asks the processor to mask address bit 20.
// [RULE_20] fp_error_n is received; ignore_fp_err_n tells processor to ignore it.
// [RULE_21] maskable_irq signals an interrupt; cpu_reset_out resets the processor.
// [RULE_22] write_read_sel stays valid until after next_addr_n or last burst_ready_n.
// [RULE_23] sys_mgmt_irq_n asserted triggers system management mode entry.
// [RULE_24] Inputs sampled and outputs changed on rising edges of the processor clock.
// [RULE_25] During cpu_reset_out, ready, next address, snoop strobe and hold stay idle.
module chbi_host_bus #(
    parameter BURST_BEATS = `CHBI_BURST_BEATS,
    parameter WAIT_CYCLES = `CHBI_WAIT_CYCLES,
    parameter INIT_CYCLES = `CHBI_INIT_PULSE_CYCLES,
    parameter RESET_CYCLES = `CHBI_RESET_CYCLES
) (
    // Clock and reset.
    input wire clk,
    input wire srst,
    // Processor cycle inputs.
    input wire addr_strobe_n,
    input wire [7:0] byte_enable_n,
    input wire data_code_sel,
    input wire mem_io_sel,
    input wire write_read_sel,
    input wire burstable_req_n,
    input wire [15:0] cpuDataLow,
    // Address pins split into input, output and enable.
    input wire [31:3] cpuAddrIn,
    output reg [31:3] cpuAddrOut,
    output reg cpuAddrOe,
    // Cycle completion outputs.
    output reg burst_ready_n,
    output reg next_addr_n,
    output reg cache_enable_n,
    // Snoop and hold.
    input wire hit_modified_n,
    input wire bus_grant_ack,
    input wire atomic_seq_n,
    output reg ext_addr_strobe_n,
    output reg snoop_invalidate,
    output reg addr_hold,
    output reg bus_request_out,
    output reg backoff_n,
    // Bus master request from the system side.
    input wire altPinMode,
    input wire masterReq,
    input wire [31:3] masterAddr,
    input wire masterWrite,
    input wire romProtect,
    output reg masterDone,
    // Processor sideband.
    input wire fp_error_n,
    input wire ignoreFpErr,
    input wire irqPending,
    input wire smiRequest,
    input wire cacheableRegion,
    output reg cpu_init,
    output reg addr20_mask_n,
    output reg ignore_fp_err_n,
    output reg maskable_irq,
    output reg sys_mgmt_irq_n,
    output reg cpu_reset_out
);

    // Cycle engine states.
    localparam S_IDLE = 3'h0;
    localparam S_WAIT = 3'h1;
    localparam S_BEAT = 3'h2;
    localparam S_REQ = 3'h3;
    localparam S_SNOOP = 3'h4;
    localparam S_CHECK = 3'h5;
    localparam S_RETRY = 3'h6;

    reg [2:0] state;
    reg [2:0] beatCount;
    reg [3:0] waitCount;
    reg cycWrite;
    reg cycIo;
    reg cycBurst;
    reg cycShutdown;
    reg [15:0] cycPort;
    reg [7:0] initCount;
    reg [7:0] resetCount;
    reg pending;

    // Decides whether a cycle is a shutdown special cycle.
    function isShutdown;
        input mio;
        input dc;
        input wr;
        input [7:0] ben;
        begin
            isShutdown = !mio && !dc && wr && (ben == 8'hfe);
        end
    endfunction

    // Returns the lowest enabled byte lane, which stands in for address bits 2 to 0.
    function [2:0] lowLane;
        input [7:0] ben;
        begin
            if (!ben[0]) begin
                lowLane = 3'h0;
            end else if (!ben[1]) begin
                lowLane = 3'h1;
            end else if (!ben[2]) begin
                lowLane = 3'h2;
            end else if (!ben[3]) begin
                lowLane = 3'h3;
            end else if (!ben[4]) begin
                lowLane = 3'h4;
            end else if (!ben[5]) begin
                lowLane = 3'h5;
            end else if (!ben[6]) begin
                lowLane = 3'h6;
            end else begin
                lowLane = 3'h7;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Processor reset generator, held for a fixed count after srst.
    always @(posedge clk) begin
        if (srst) begin
            resetCount <= 8'h00;
            cpu_reset_out <= 1'b1;
        end else if (resetCount != RESET_CYCLES[7:0]) begin
            resetCount <= resetCount + 8'h01;
            cpu_reset_out <= 1'b1; // [RULE_21]
        end else begin
            cpu_reset_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cycle engine: processor cycles, pipelining and snooping master cycles.
    always @(posedge clk) begin
        if (srst || cpu_reset_out) begin
            state <= S_IDLE; // [RULE_25]
            burst_ready_n <= 1'b1;
            next_addr_n <= 1'b1;
            cache_enable_n <= 1'b1;
            ext_addr_strobe_n <= 1'b1;
            snoop_invalidate <= 1'b0;
            addr_hold <= 1'b0;
            bus_request_out <= 1'b0;
            backoff_n <= 1'b1;
            cpuAddrOut <= 29'h0;
            cpuAddrOe <= 1'b0;
            masterDone <= 1'b0;
            beatCount <= 3'h0;
            waitCount <= 4'h0;
            cycWrite <= 1'b0;
            cycIo <= 1'b0;
            cycBurst <= 1'b0;
            cycShutdown <= 1'b0;
            cycPort <= 16'h0;
            pending <= 1'b0;
        end else begin
            burst_ready_n <= 1'b1;
            next_addr_n <= 1'b1;
            ext_addr_strobe_n <= 1'b1;
            masterDone <= 1'b0;
            // A new strobe during a pipelined cycle is remembered.
            if (!addr_strobe_n && state != S_IDLE) begin
                pending <= 1'b1; // [RULE_07]
            end
            case (state)
                S_IDLE: begin
                    if (!addr_strobe_n || pending) begin // [RULE_02] [RULE_24]
                        pending <= 1'b0;
                        cycWrite <= write_read_sel; // [RULE_22]
                        cycIo <= !mem_io_sel; // [RULE_05]
                        cycBurst <= !burstable_req_n && mem_io_sel; // [RULE_09]
                        cycShutdown <= isShutdown(mem_io_sel, data_code_sel,
                            write_read_sel, byte_enable_n); // [RULE_03] [RULE_04]
                        cycPort <= {cpuAddrIn[15:3], lowLane(byte_enable_n)}; // [RULE_03]
                        cache_enable_n <= !(cacheableRegion && mem_io_sel
                            && !write_read_sel); // [RULE_08]
                        waitCount <= WAIT_CYCLES[3:0];
                        beatCount <= 3'h0;
                        state <= S_WAIT;
                    end else if (masterReq && atomic_seq_n) begin // [RULE_17]
                        bus_request_out <= !altPinMode; // [RULE_15]
                        backoff_n <= !altPinMode; // [RULE_16]
                        state <= S_REQ;
                    end
                end
                S_WAIT: begin
                    if (waitCount != 4'h0) begin
                        waitCount <= waitCount - 4'h1;
                    end else begin
                        state <= S_BEAT;
                        burst_ready_n <= 1'b0; // [RULE_06]
                        next_addr_n <= cycBurst; // [RULE_07]
                    end
                end
                S_BEAT: begin
                    if (cycBurst && beatCount != BURST_BEATS[2:0] - 3'h1) begin
                        beatCount <= beatCount + 3'h1;
                        burst_ready_n <= 1'b0; // [RULE_06]
                    end else begin
                        cache_enable_n <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                S_REQ: begin
                    if (altPinMode || bus_grant_ack) begin // [RULE_15]
                        addr_hold <= romProtect; // [RULE_13]
                        cpuAddrOut <= masterAddr;
                        cpuAddrOe <= 1'b1; // [RULE_10]
                        state <= S_SNOOP;
                    end
                end
                S_SNOOP: begin
                    ext_addr_strobe_n <= 1'b0; // [RULE_11]
                    snoop_invalidate <= masterWrite; // [RULE_14]
                    waitCount <= 4'h2;
                    state <= S_CHECK;
                end
                S_CHECK: begin
                    if (!hit_modified_n) begin
                        cpuAddrOe <= 1'b0; // [RULE_12]
                        bus_request_out <= 1'b0;
                        backoff_n <= 1'b1;
                        state <= S_RETRY;
                    end else if (waitCount != 4'h0) begin
                        waitCount <= waitCount - 4'h1;
                    end else begin
                        masterDone <= 1'b1;
                        cpuAddrOe <= 1'b0;
                        addr_hold <= 1'b0;
                        snoop_invalidate <= 1'b0;
                        bus_request_out <= 1'b0;
                        backoff_n <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                S_RETRY: begin
                    if (hit_modified_n && !bus_grant_ack) begin
                        addr_hold <= 1'b0; // [RULE_12]
                        snoop_invalidate <= 1'b0;
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sideband controls: init pulse, address bit 20 gate, interrupts.
    always @(posedge clk) begin
        if (srst) begin
            initCount <= 8'h00;
            cpu_init <= 1'b0;
            addr20_mask_n <= 1'b0;
            ignore_fp_err_n <= 1'b1;
            maskable_irq <= 1'b0;
            sys_mgmt_irq_n <= 1'b1;
        end else begin
            maskable_irq <= irqPending; // [RULE_21]
            sys_mgmt_irq_n <= !smiRequest; // [RULE_23]
            ignore_fp_err_n <= !(ignoreFpErr && !fp_error_n); // [RULE_20] [RULE_01]
            // I/O writes finishing on the last beat are decoded here.
            if (state == S_BEAT && cycIo && cycWrite
                && cycPort == `CHBI_PORT_SYSCTL) begin
                addr20_mask_n <= cpuDataLow[`CHBI_SYSCTL_A20_BIT]; // [RULE_19]
            end
            if (state == S_BEAT && ((cycIo && cycWrite && ((cycPort == `CHBI_PORT_KBC
                && cpuDataLow[7:0] == `CHBI_KBC_RESET_CMD) || (cycPort == `CHBI_PORT_SYSCTL
                && cpuDataLow[`CHBI_SYSCTL_INIT_BIT]))) || cycShutdown)) begin
                initCount <= INIT_CYCLES[7:0]; // [RULE_18]
                cpu_init <= 1'b1;
            end else if (initCount != 8'h00) begin
                initCount <= initCount - 8'h01;
            end else begin
                cpu_init <= 1'b0;
            end
        end
    end

endmodule

/* File: bench/chbi_host_bus_sva.sv */
// Checker on the host bus interface ports.
`timescale 1ns/1ps
module chbi_host_bus_sva (
    // Watched ports.
    input wire clk, input wire srst, input wire addr_strobe_n, input wire mem_io_sel,
    input wire write_read_sel, input wire burst_ready_n, input wire next_addr_n,
    input wire cache_enable_n, input wire ext_addr_strobe_n, input wire cpuAddrOe,
    input wire snoop_invalidate, input wire masterWrite, input wire addr_hold,
    input wire romProtect, input wire bus_grant_ack, input wire bus_request_out,
    input wire backoff_n, input wire altPinMode, input wire atomic_seq_n,
    input wire cpu_reset_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////
    // Completion, snoop and hold relations.
    property p_rst; cpu_reset_out |-> burst_ready_n && next_addr_n && ext_addr_strobe_n
        && !bus_request_out; endproperty
    a_rst: assert property (p_rst) else $error("handshake active in reset");
    property p_ans; !addr_strobe_n && burst_ready_n && !cpu_reset_out |-> ##3 !burst_ready_n;
    endproperty
    a_ans: assert property (p_ans) else $error("ready late");
    property p_brst; $fell(burst_ready_n) && next_addr_n |=> !burst_ready_n[*3] ##1 burst_ready_n;
    endproperty
    a_brst: assert property (p_brst) else $error("burst not four beats");
    property p_na; !next_addr_n |-> $fell(burst_ready_n) ##1 next_addr_n; endproperty
    a_na: assert property (p_na) else $error("next address misplaced");
    property p_ken; !cache_enable_n |-> mem_io_sel && !write_read_sel; endproperty
    a_ken: assert property (p_ken) else $error("cacheable on bad cycle");
    property p_ext_addr_strobe_n; $fell(ext_addr_strobe_n) |-> cpuAddrOe ##1 ext_addr_strobe_n; endproperty
    a_ext_addr_strobe_n: assert property (p_ext_addr_strobe_n) else $error("snoop strobe bad");
    property p_inv; !ext_addr_strobe_n |-> snoop_invalidate == masterWrite; endproperty
    a_inv: assert property (p_inv) else $error("invalidate wrong");
    property p_hold; !ext_addr_strobe_n |-> addr_hold == romProtect; endproperty
    a_hold: assert property (p_hold) else $error("address hold wrong");
    property p_grant; $rose(cpuAddrOe) && !altPinMode |-> $past(bus_grant_ack); endproperty
    a_grant: assert property (p_grant) else $error("bus taken early");
    property p_backoff_n; $fell(backoff_n) |-> altPinMode && $past(atomic_seq_n); endproperty
    a_backoff_n: assert property (p_backoff_n) else $error("backoff bad");
    // Main scenarios reached.
    cover property ($fell(burst_ready_n) && next_addr_n);
    cover property ($fell(ext_addr_strobe_n) && masterWrite);
    cover property ($fell(backoff_n));
endmodule
bind chbi_host_bus chbi_host_bus_sva chk_i (.*);

/* File: bench/chbi_cpu_model.sv */
// Processor model facing the host bus interface.
`timescale 1ns/1ps
module chbi_cpu_model (
    input wire clk, input wire burst_ready_n, input wire cache_enable_n,
    input wire ext_addr_strobe_n, input wire bus_request_out, input wire altPinMode,
    output logic addr_strobe_n, output logic [7:0] byte_enable_n, output logic data_code_sel,
    output logic mem_io_sel, output logic write_read_sel, output logic burstable_req_n,
    output logic [15:0] cpuDataLow, output logic [31:3] modelAddr, output logic hit_modified_n,
    output logic bus_grant_ack, output logic atomic_seq_n, output logic fp_error_n
);
    int hitCount = 0;
    // Idle bus at time zero.
    initial begin
        {addr_strobe_n, burstable_req_n, atomic_seq_n, fp_error_n, hit_modified_n} = 5'h1f;
        {byte_enable_n, mem_io_sel, data_code_sel, write_read_sel, bus_grant_ack} = 12'hff0;
        {modelAddr, cpuDataLow} = '0;
    end
    // Hold granted a cycle after the request; a snoop may hit a modified line.
    always @(posedge clk) begin
        bus_grant_ack <= bus_request_out && !altPinMode && hit_modified_n;
        hit_modified_n <= !(!ext_addr_strobe_n && hitCount > 0);
        if (!ext_addr_strobe_n && hitCount > 0)
            hitCount <= hitCount - 1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // One bus cycle; counts ready beats and cacheable beats.
    task automatic cyc(input logic [3:0] mdwb, input logic [7:0] be, input logic [31:3] a,
            input logic [15:0] dat, output int beats, output int kens);
        beats = 0;
        kens = 0;
        @(posedge clk);
        #1;
        {mem_io_sel, data_code_sel, write_read_sel, burstable_req_n} = mdwb;
        {byte_enable_n, modelAddr, cpuDataLow} = {be, a, dat};
        addr_strobe_n = 0;
        @(posedge clk);
        #1;
        addr_strobe_n = 1;
        repeat (12) begin
            @(posedge clk);
            #1;
            if (burst_ready_n === 0) begin
                beats++;
                kens += !cache_enable_n;
            end else if (beats > 0)
                break;
        end
        // Hold time is over, so the lines stop showing the last value.
        {mem_io_sel, data_code_sel, write_read_sel} = ~mdwb[3:1];
        {byte_enable_n, modelAddr, cpuDataLow} = ~{be, a, dat};
    endtask
endmodule

/* File: bench/test_cpu_host_bus_interface.sv */
// Self-checking bench for the processor host bus interface.
`timescale 1ns/1ps
module test_cpu_host_bus_interface;
    logic clk = 0, srst = 1, altPinMode = 0, masterReq = 0, masterWrite = 0, romProtect = 0;
    logic ignoreFpErr = 0, irqPending = 0, smiRequest = 0, cacheableRegion = 0;
    logic [31:3] masterAddr = 29'h00abcde;
    wire addr_strobe_n, data_code_sel, mem_io_sel, write_read_sel, burstable_req_n, masterDone;
    wire hit_modified_n, bus_grant_ack, atomic_seq_n, fp_error_n, cpuAddrOe, cpu_init;
    wire burst_ready_n, next_addr_n, cache_enable_n, ext_addr_strobe_n, snoop_invalidate;
    wire addr_hold, bus_request_out, backoff_n, addr20_mask_n, ignore_fp_err_n;
    wire maskable_irq, sys_mgmt_irq_n, cpu_reset_out;
    wire [7:0] byte_enable_n;
    wire [15:0] cpuDataLow;
    wire [31:3] cpuAddrIn, cpuAddrOut, modelAddr;
    int mismatches = 0, check_count = 0, cycles = 0, n, k, b;
    // Address pins show the device's address while it drives them.
    assign cpuAddrIn = cpuAddrOe ? cpuAddrOut : modelAddr;
    chbi_host_bus #(.INIT_CYCLES(4), .RESET_CYCLES(4)) dut (.*);
    chbi_cpu_model cpu (.*);
    // Clock and cycle ceiling.
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // Reset, then the processor reset pulse and sideband defaults.
    task automatic rst;
        srst = 1;
        tick(4);
        srst = 0;
        tick(2);
        chk({cpu_reset_out, addr20_mask_n, ignore_fp_err_n}, 3'b101);
        tick(4);
        chk(cpu_reset_out, 0);
    endtask
    task automatic run(input logic [3:0] mdwb, input logic [7:0] be, input logic [31:3] a,
            input logic [7:0] d, input int eb, input int ek);
        cpu.cyc(mdwb, be, a, {d, d}, n, k);
        chk(n, eb);
        chk(k, ek);
    endtask
    task automatic initPulse;
        n = 0;
        repeat (30) begin
            n += cpu_init;
            tick(1);
        end
        chk(n, 5);
    endtask
    // Port writes, shutdown and interrupt pins.
    task automatic tSide;
        run(4'b0111, 8'hfb, 29'h12, 8'h02, 1, 0);
        chk(addr20_mask_n, 1);
        run(4'b0111, 8'hef, 29'h0c, 8'hfe, 1, 0);
        initPulse;
        run(4'b0111, 8'hfb, 29'h12, 8'h01, 1, 0);
        initPulse;
        chk(addr20_mask_n, 0);
        run(4'b0011, 8'hfe, 29'h0, 8'h00, 1, 0);
        initPulse;
        {irqPending, smiRequest, ignoreFpErr, cpu.fp_error_n} = 4'b1110;
        tick(3);
        chk({maskable_irq, sys_mgmt_irq_n, ignore_fp_err_n}, 3'b100);
        {irqPending, smiRequest, cpu.fp_error_n} = 3'b001;
        tick(3);
        chk({maskable_irq, sys_mgmt_irq_n, ignore_fp_err_n}, 3'b011);
    endtask
    // Master snoop; a modified hit forces a retry.
    task automatic tMaster(input logic w, input int hits);
        {masterWrite, romProtect, masterReq, n, k, b} = {w, w, 1'b1, 96'h0};
        cpu.hitCount = hits;
        repeat (80) begin
            tick(1);
            b += !backoff_n;
            if (!ext_addr_strobe_n) begin
                n++;
                chk(cpuAddrIn, masterAddr);
            end
            if (masterDone === 1) begin
                k++;
                masterReq = 0;
            end
        end
        chk(n, hits + 1);
        chk(k, 1);
    endtask
    // A locked sequence holds backoff off until it ends.
    task automatic tBoff;
        {altPinMode, cpu.atomic_seq_n, masterReq} = 3'b101;
        tick(10);
        chk(backoff_n, 1);
        cpu.atomic_seq_n = 1;
        tMaster(0, 0);
        chk(b > 0, 1);
        altPinMode = 0;
    endtask
    initial begin
        rst;
        run(4'b0101, 8'hf0, 29'h40, 8'h00, 1, 0);
        cacheableRegion = 1;
        run(4'b1100, 8'h00, 29'h80, 8'h00, 4, 4);
        run(4'b1111, 8'h0f, 29'h88, 8'h00, 1, 0);
        cacheableRegion = 0;
        tSide;
        tMaster(0, 0);
        tMaster(1, 1);
        tBoff;
        rst;
        summarize;
    end
endmodule
